// *** common/dtc_if.sv ***
// carriers between the timer core and its count bytes and samplers
`timescale 1ns/100ps
`default_nettype none
interface dtc_cnt_if;
	logic wr;
	logic [7:0] wdata;
	logic inc;
	logic load;
	logic [7:0] load_val;
	logic wrap5;
	logic [7:0] value;
	logic carry;
	modport ctl (output wr, wdata, inc, load, load_val, wrap5,
		input value, carry);
	modport cnt (input wr, wdata, inc, load, load_val, wrap5,
		output value, carry);
endinterface : dtc_cnt_if

interface dtc_smp_if;
	logic mtick;
	logic pin;
	logic sample;
	logic fall;
	logic low;
	modport ctl (output mtick, pin, input sample, fall, low);
	modport smp (input mtick, pin, output sample, fall, low);
endinterface : dtc_smp_if
`default_nettype wire

// *** common/dtc_pkg.sv ***
// constants and types shared by the dual timer/counter
package dtc_pkg;
	localparam logic [7:0] ADDR_TIMER_RUN_AND_FLAG_CONTROL = 8'h88;
	localparam logic [7:0] ADDR_TIMER_MODE_CONTROL = 8'h89;
	localparam logic [7:0] ADDR_ZERO_LOW_BYTE = 8'h8a;
	localparam logic [7:0] ADDR_ONE_LOW_BYTE = 8'h8b;
	localparam logic [7:0] ADDR_ZERO_HIGH_BYTE = 8'h8c;
	localparam logic [7:0] ADDR_ONE_HIGH_BYTE = 8'h8d;
	localparam logic [7:0] RESET_RUN_AND_FLAG = 8'h00;
	localparam logic [7:0] RESET_MODE = 8'h00;
	localparam logic [7:0] RESET_COUNT = 8'h00;
	localparam logic [7:0] READ_UNMAPPED = 8'h00;
	// control register field positions
	localparam int BIT_ONE_OVERFLOW_FLAG = 7;
	localparam int BIT_ONE_RUN_BIT = 6;
	localparam int BIT_ZERO_OVERFLOW_FLAG = 5;
	localparam int BIT_ZERO_RUN_BIT = 4;
	localparam int BIT_EXT_IRQ_ONE_FLAG = 3;
	localparam int BIT_EXT_IRQ_ONE_TYPE = 2;
	localparam int BIT_EXT_IRQ_ZERO_FLAG = 1;
	localparam int BIT_EXT_IRQ_ZERO_TYPE = 0;
	// mode register field positions
	localparam int BIT_ONE_GATE = 7;
	localparam int BIT_ONE_COUNTER_SELECT = 6;
	localparam int BIT_ONE_MODE_HIGH = 5;
	localparam int BIT_ONE_MODE_LOW = 4;
	localparam int BIT_ZERO_GATE = 3;
	localparam int BIT_ZERO_COUNTER_SELECT = 2;
	localparam int BIT_ZERO_MODE_HIGH = 1;
	localparam int BIT_ZERO_MODE_LOW = 0;
	// machine cycle timing
	localparam int OSC_PERIOD_NS = 20;
	localparam int OSC_PER_MCYCLE = 6;
	localparam int MCYCLE_NS = OSC_PERIOD_NS * OSC_PER_MCYCLE;
	localparam int MCYCLE_CLOCKS = MCYCLE_NS / OSC_PERIOD_NS;
	localparam logic [2:0] MCYCLE_LAST = 3'(MCYCLE_CLOCKS - 1);
	localparam logic [2:0] MCYCLE_ZERO = 3'h0;
	localparam logic [4:0] PRESCALE_ALL_ONES = 5'h1f;
	localparam logic [7:0] BYTE_ALL_ONES = 8'hff;
	typedef enum logic [1:0] {
		DTC_MODE_13BIT = 2'h0,
		DTC_MODE_16BIT = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT = 2'h3
	} dtc_mode_type;
endpackage : dtc_pkg

// *** core/dtc_count_byte.sv ***
// one 8-bit count byte with write, reload and increment
`timescale 1ns/100ps
`default_nettype none
module dtc_count_byte
	import dtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	dtc_cnt_if.cnt bus
);
	logic [7:0] value;
	wire logic low_wrap = (value[4:0] == PRESCALE_ALL_ONES);
	wire logic full_wrap = (value == BYTE_ALL_ONES);

	// software write beats any count in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			value <= RESET_COUNT;
		end else if (bus.wr) begin
			value <= bus.wdata;
		end else if (bus.load) begin
			value <= bus.load_val;
		end else if (bus.inc) begin
			value <= value + 8'h01;
		end
	end

	assign bus.value = value;
	// a wrap that a software write overrides never happened
	assign bus.carry = bus.inc & ~bus.wr &
		(bus.wrap5 ? low_wrap : full_wrap);
endmodule : dtc_count_byte
`default_nettype wire

// *** core/dtc_pin_sampler.sv ***
// once-per-machine-cycle pin sampler with fall and low detection
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_sampler
	import dtc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	dtc_smp_if.smp bus
);
	logic sample;
	logic fall;
	logic low;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sample <= 1'b1;
			fall <= 1'b0;
			low <= 1'b0;
		end else begin
			fall <= bus.mtick & sample & ~bus.pin;
			low <= bus.mtick & ~bus.pin;
			if (bus.mtick) begin
				sample <= bus.pin;
			end
		end
	end

	assign bus.sample = sample;
	assign bus.fall = fall;
	assign bus.low = low;
endmodule : dtc_pin_sampler
`default_nettype wire

// *** core/dtc_top.sv ***
// dual timer/counter with run/flag and mode control registers
`timescale 1ns/100ps
`default_nettype none
module dtc_top
	import dtc_pkg::*;
(
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_BIT_WR,
	input wire logic [2:0] SFR_BIT_SEL,
	input wire logic SFR_BIT_VAL,
	output logic [7:0] SFR_RDATA,
	input wire logic ZERO_COUNT_PIN,
	input wire logic ONE_COUNT_PIN,
	input wire logic EXT_IRQ_ZERO_PIN_N,
	input wire logic EXT_IRQ_ONE_PIN_N,
	input wire logic ACK_ZERO_TIMER,
	input wire logic ACK_ONE_TIMER,
	input wire logic ACK_EXT_ZERO,
	input wire logic ACK_EXT_ONE,
	output logic ZERO_TIMER_IRQ,
	output logic ONE_TIMER_IRQ,
	output logic EXT_ZERO_IRQ,
	output logic EXT_ONE_IRQ,
	output logic ONE_OVERFLOW_PULSE
);
	logic [7:0] run_flag;
	logic [7:0] mode_reg;
	logic [2:0] div;
	logic mtick;
	logic one_ovf_pulse;
	logic [7:0] rdata;

	dtc_cnt_if zl ();
	dtc_cnt_if zh ();
	dtc_cnt_if ol ();
	dtc_cnt_if oh ();
	dtc_smp_if zc ();
	dtc_smp_if oc ();
	dtc_smp_if ze ();
	dtc_smp_if oe ();

	dtc_count_byte u_zero_low (.clk(CLOCK), .rst(SYS_RST), .bus(zl));
	dtc_count_byte u_zero_high (.clk(CLOCK), .rst(SYS_RST), .bus(zh));
	dtc_count_byte u_one_low (.clk(CLOCK), .rst(SYS_RST), .bus(ol));
	dtc_count_byte u_one_high (.clk(CLOCK), .rst(SYS_RST), .bus(oh));
	dtc_pin_sampler u_zero_cnt (.clk(CLOCK), .rst(SYS_RST), .bus(zc));
	dtc_pin_sampler u_one_cnt (.clk(CLOCK), .rst(SYS_RST), .bus(oc));
	dtc_pin_sampler u_zero_ext (.clk(CLOCK), .rst(SYS_RST), .bus(ze));
	dtc_pin_sampler u_one_ext (.clk(CLOCK), .rst(SYS_RST), .bus(oe));

	// machine cycle enable
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			div <= MCYCLE_ZERO;
			mtick <= 1'b0;
		end else begin
			mtick <= (div == MCYCLE_LAST);
			div <= (div == MCYCLE_LAST) ? MCYCLE_ZERO : div + 3'h1;
		end
	end

	assign zc.mtick = mtick;
	assign oc.mtick = mtick;
	assign ze.mtick = mtick;
	assign oe.mtick = mtick;
	assign zc.pin = ZERO_COUNT_PIN;
	assign oc.pin = ONE_COUNT_PIN;
	assign ze.pin = EXT_IRQ_ZERO_PIN_N;
	assign oe.pin = EXT_IRQ_ONE_PIN_N;

	// mode register fields
	wire dtc_mode_type zero_mode = dtc_mode_type'(
		{mode_reg[BIT_ZERO_MODE_HIGH], mode_reg[BIT_ZERO_MODE_LOW]});
	wire dtc_mode_type one_mode = dtc_mode_type'(
		{mode_reg[BIT_ONE_MODE_HIGH], mode_reg[BIT_ONE_MODE_LOW]});
	wire logic zero_gate = mode_reg[BIT_ZERO_GATE];
	wire logic one_gate = mode_reg[BIT_ONE_GATE];
	wire logic zero_ct = mode_reg[BIT_ZERO_COUNTER_SELECT];
	wire logic one_ct = mode_reg[BIT_ONE_COUNTER_SELECT];
	wire logic zero_run_bit = run_flag[BIT_ZERO_RUN_BIT];
	wire logic one_run_bit = run_flag[BIT_ONE_RUN_BIT];
	wire logic zero_split = (zero_mode == DTC_MODE_SPLIT);
	wire logic one_split = (one_mode == DTC_MODE_SPLIT);

	// gating: the run bit only enables, it never clears the count
	wire logic zero_run = zero_run_bit &
		(~zero_gate | EXT_IRQ_ZERO_PIN_N);
	// timer 0 split mode borrows the timer 1 run bit for its high byte
	wire logic one_run = (zero_split | one_run_bit) &
		(~one_gate | EXT_IRQ_ONE_PIN_N) & ~one_split;
	wire logic zero_src = zero_ct ? zc.fall : mtick;
	wire logic one_src = one_ct ? oc.fall : mtick;
	wire logic zero_en = zero_run & zero_src;
	wire logic one_en = one_run & one_src;

	// timer 0 low byte
	assign zl.inc = zero_en;
	assign zl.wrap5 = (zero_mode == DTC_MODE_13BIT);
	assign zl.load = (zero_mode == DTC_MODE_RELOAD) & zl.carry;
	assign zl.load_val = zh.value;

	// timer 0 high byte: cascade, idle in reload, cycle timer in split
	wire logic zh_cascade = (zero_mode == DTC_MODE_13BIT) |
		(zero_mode == DTC_MODE_16BIT);
	assign zh.inc = zh_cascade ? zl.carry :
		(zero_split & one_run_bit & mtick);
	assign zh.wrap5 = 1'b0;
	assign zh.load = 1'b0;
	assign zh.load_val = RESET_COUNT;

	// timer 1 bytes
	wire logic oh_cascade = (one_mode == DTC_MODE_13BIT) |
		(one_mode == DTC_MODE_16BIT);
	assign ol.inc = one_en;
	assign ol.wrap5 = (one_mode == DTC_MODE_13BIT);
	assign ol.load = (one_mode == DTC_MODE_RELOAD) & ol.carry;
	assign ol.load_val = oh.value;
	assign oh.inc = oh_cascade & ol.carry;
	assign oh.wrap5 = 1'b0;
	assign oh.load = 1'b0;
	assign oh.load_val = RESET_COUNT;

	// overflow events
	wire logic zero_ovf = zh_cascade ? zh.carry : zl.carry;
	wire logic one_ovf = oh_cascade ? oh.carry : ol.carry;
	// with timer 0 split, timer 1 overflows raise no flag
	wire logic set_one_flag = zero_split ? zh.carry : one_ovf;

	// software writes to count bytes
	wire logic wr_zl = SFR_WR & (SFR_ADDR == ADDR_ZERO_LOW_BYTE);
	wire logic wr_zh = SFR_WR & (SFR_ADDR == ADDR_ZERO_HIGH_BYTE);
	wire logic wr_ol = SFR_WR & (SFR_ADDR == ADDR_ONE_LOW_BYTE);
	wire logic wr_oh = SFR_WR & (SFR_ADDR == ADDR_ONE_HIGH_BYTE);
	assign zl.wr = wr_zl;
	assign zh.wr = wr_zh;
	assign ol.wr = wr_ol;
	assign oh.wr = wr_oh;
	assign zl.wdata = SFR_WDATA;
	assign zh.wdata = SFR_WDATA;
	assign ol.wdata = SFR_WDATA;
	assign oh.wdata = SFR_WDATA;

	// control register: byte write or single bit write
	wire logic wr_ctl_byte = SFR_WR &
		(SFR_ADDR == ADDR_TIMER_RUN_AND_FLAG_CONTROL);
	wire logic wr_mode = SFR_WR & (SFR_ADDR == ADDR_TIMER_MODE_CONTROL);
	wire logic [7:0] bit_mask = SFR_BIT_WR ?
		(8'h01 << SFR_BIT_SEL) : 8'h00;
	wire logic [7:0] wr_mask = wr_ctl_byte ? 8'hff : bit_mask;
	wire logic [7:0] wr_val = wr_ctl_byte ? SFR_WDATA : {8{SFR_BIT_VAL}};
	wire logic [7:0] after_sw = (run_flag & ~wr_mask) |
		(wr_val & wr_mask);

	// external interrupt triggers
	wire logic ext_zero_set = run_flag[BIT_EXT_IRQ_ZERO_TYPE] ?
		ze.fall : ze.low;
	wire logic ext_one_set = run_flag[BIT_EXT_IRQ_ONE_TYPE] ?
		oe.fall : oe.low;

	wire logic [7:0] ack_mask = {ACK_ONE_TIMER, 1'b0, ACK_ZERO_TIMER,
		1'b0, ACK_EXT_ONE, 1'b0, ACK_EXT_ZERO, 1'b0};
	wire logic [7:0] set_mask = {set_one_flag, 1'b0, zero_ovf, 1'b0,
		ext_one_set, 1'b0, ext_zero_set, 1'b0};
	// a hardware set always beats a clear in the same cycle
	wire logic [7:0] next_run_flag = (after_sw & ~ack_mask) |
		set_mask;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			run_flag <= RESET_RUN_AND_FLAG;
		end else begin
			run_flag <= next_run_flag;
		end
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			mode_reg <= RESET_MODE;
		end else if (wr_mode) begin
			mode_reg <= SFR_WDATA;
		end
	end

	// baud pulse follows timer 1 even when its flag is taken over
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			one_ovf_pulse <= 1'b0;
		end else begin
			one_ovf_pulse <= one_ovf;
		end
	end

	// read mux, registered so data is stable one cycle after address
	wire logic [7:0] read_mux =
		(SFR_ADDR == ADDR_TIMER_RUN_AND_FLAG_CONTROL) ? run_flag :
		(SFR_ADDR == ADDR_TIMER_MODE_CONTROL) ? mode_reg :
		(SFR_ADDR == ADDR_ZERO_LOW_BYTE) ? zl.value :
		(SFR_ADDR == ADDR_ZERO_HIGH_BYTE) ? zh.value :
		(SFR_ADDR == ADDR_ONE_LOW_BYTE) ? ol.value :
		(SFR_ADDR == ADDR_ONE_HIGH_BYTE) ? oh.value : READ_UNMAPPED;

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata <= READ_UNMAPPED;
		end else begin
			rdata <= read_mux;
		end
	end

	assign SFR_RDATA = rdata;
	assign ZERO_TIMER_IRQ = run_flag[BIT_ZERO_OVERFLOW_FLAG];
	assign ONE_TIMER_IRQ = run_flag[BIT_ONE_OVERFLOW_FLAG];
	assign EXT_ZERO_IRQ = run_flag[BIT_EXT_IRQ_ZERO_FLAG];
	assign EXT_ONE_IRQ = run_flag[BIT_EXT_IRQ_ONE_FLAG];
	assign ONE_OVERFLOW_PULSE = one_ovf_pulse;
endmodule : dtc_top
`default_nettype wire

// *** verification/dtc_pins.sv ***
// pin-side model: count pins and active-low interrupt pins
`timescale 1ns/100ps
`default_nettype none
module dtc_pins (
	input wire logic clk,
	output logic cnt0,
	output logic cnt1,
	output logic irq0_n,
	output logic irq1_n
);
	// pull-ups: all pins idle high
	initial {cnt0, cnt1, irq0_n, irq1_n} = 4'b1111;
	// hold each level whole machine cycles or the sampler may miss it
	task automatic fall(input int hold);
		repeat (hold) @(posedge clk);
		// both count pins fall together
		{cnt0, cnt1} <= 2'b00;
		repeat (hold) @(posedge clk);
		{cnt0, cnt1} <= 2'b11;
	endtask : fall
	task automatic irq(input int i, input logic v);
		@(posedge clk);
		if (i == 0)
			irq0_n <= v;
		else
			irq1_n <= v;
	endtask : irq
endmodule : dtc_pins
`default_nettype wire

// *** verification/dtc_top_asserts.sv ***
// port-level checks for the dual timer/counter
`timescale 1ns/100ps
`default_nettype none
module dtc_top_asserts (
	input wire logic CLOCK,
	input wire logic SYS_RST,
	input wire logic [7:0] SFR_ADDR,
	input wire logic SFR_WR,
	input wire logic [7:0] SFR_WDATA,
	input wire logic SFR_BIT_WR,
	input wire logic [2:0] SFR_BIT_SEL,
	input wire logic SFR_BIT_VAL,
	input wire logic [7:0] SFR_RDATA,
	input wire logic EXT_IRQ_ONE_PIN_N,
	input wire logic ACK_ZERO_TIMER,
	input wire logic ACK_EXT_ZERO,
	input wire logic ACK_EXT_ONE,
	input wire logic ZERO_TIMER_IRQ,
	input wire logic ONE_TIMER_IRQ,
	input wire logic EXT_ZERO_IRQ,
	input wire logic EXT_ONE_IRQ,
	input wire logic ONE_OVERFLOW_PULSE
);
	logic [7:0] mode_shadow;
	logic [7:0] ctl_shadow;
	wire logic [7:0] ctl_view;
	// software-owned bits come from the shadow, flags from the outputs
	assign ctl_view = {ONE_TIMER_IRQ, ctl_shadow[6], ZERO_TIMER_IRQ,
		ctl_shadow[4], EXT_ONE_IRQ, ctl_shadow[2], EXT_ZERO_IRQ, ctl_shadow[0]};
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST)
			mode_shadow <= 8'h00;
		else if (SFR_WR && SFR_ADDR == 8'h89)
			mode_shadow <= SFR_WDATA;
	end
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST)
			ctl_shadow <= 8'h00;
		else if (SFR_WR && SFR_ADDR == 8'h88)
			ctl_shadow <= SFR_WDATA;
		else if (SFR_BIT_WR)
			ctl_shadow[SFR_BIT_SEL] <= SFR_BIT_VAL;
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	sequence s_low8;
		(!EXT_IRQ_ONE_PIN_N && !ctl_shadow[2] && !ACK_EXT_ONE && !SFR_WR)[*8];
	endsequence
	property p_ctl_read;
		$past(SFR_ADDR) == 8'h88 |-> SFR_RDATA == $past(ctl_view);
	endproperty
	a_ctl_read: assert property (p_ctl_read)
		else $error("control read differs");
	property p_pulse_gap;
		ONE_OVERFLOW_PULSE |=> !ONE_OVERFLOW_PULSE [*5];
	endproperty
	a_pulse_gap: assert property (p_pulse_gap)
		else $error("overflow pulse too long");
	property p_pulse_flag;
		ONE_OVERFLOW_PULSE && $past(mode_shadow[1:0]) != 2'h3
		|-> ONE_TIMER_IRQ;
	endproperty
	a_pulse_flag: assert property (p_pulse_flag)
		else $error("overflow without flag");
	property p_t1_stop;
		$past(mode_shadow[5:4]) == 2'h3 && $past(mode_shadow[5:4], 2) == 2'h3
		|-> !ONE_OVERFLOW_PULSE;
	endproperty
	a_t1_stop: assert property (p_t1_stop)
		else $error("stopped timer overflowed");
	property p_flag_hold;
		EXT_ZERO_IRQ && !ACK_EXT_ZERO && !SFR_WR && !SFR_BIT_WR
		|=> EXT_ZERO_IRQ;
	endproperty
	a_flag_hold: assert property (p_flag_hold)
		else $error("ext flag lost");
	property p_ack_clear;
		ACK_ZERO_TIMER && !SFR_WR && !SFR_BIT_WR && !ctl_shadow[4]
		&& !$past(ctl_shadow[4]) |=> !ZERO_TIMER_IRQ;
	endproperty
	a_ack_clear: assert property (p_ack_clear)
		else $error("ack did not clear");
	property p_level;
		s_low8 |-> ##[0:6] EXT_ONE_IRQ;
	endproperty
	a_level: assert property (p_level)
		else $error("low level not flagged");
	property p_stopped;
		$past(SFR_ADDR) == 8'h8a && $past(SFR_ADDR, 2) == 8'h8a
		&& !$past(SFR_WR) && !$past(SFR_WR, 2) && !$past(ctl_shadow[4])
		&& !$past(ctl_shadow[4], 2) && !$past(ctl_shadow[4], 3)
		|-> $stable(SFR_RDATA);
	endproperty
	a_stopped: assert property (p_stopped)
		else $error("stopped count moved");
endmodule : dtc_top_asserts
bind dtc_top dtc_top_asserts u_dtc_top_asserts (
	.CLOCK(CLOCK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR),
	.SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_BIT_WR(SFR_BIT_WR),
	.SFR_BIT_SEL(SFR_BIT_SEL), .SFR_BIT_VAL(SFR_BIT_VAL),
	.SFR_RDATA(SFR_RDATA), .EXT_IRQ_ONE_PIN_N(EXT_IRQ_ONE_PIN_N),
	.ACK_ZERO_TIMER(ACK_ZERO_TIMER), .ACK_EXT_ZERO(ACK_EXT_ZERO),
	.ACK_EXT_ONE(ACK_EXT_ONE), .ZERO_TIMER_IRQ(ZERO_TIMER_IRQ),
	.ONE_TIMER_IRQ(ONE_TIMER_IRQ), .EXT_ZERO_IRQ(EXT_ZERO_IRQ),
	.EXT_ONE_IRQ(EXT_ONE_IRQ), .ONE_OVERFLOW_PULSE(ONE_OVERFLOW_PULSE)
);
`default_nettype wire

// *** verification/tb_dtc_top.sv ***
// self-checking bench for the dual timer/counter
`timescale 1ns/100ps
`default_nettype none
module tb_dtc_top
	import dtc_pkg::*;
;
	logic CLOCK, SYS_RST, SFR_WR, SFR_BIT_WR, SFR_BIT_VAL;
	logic [7:0] SFR_ADDR, SFR_WDATA;
	logic [2:0] SFR_BIT_SEL;
	logic [3:0] ack;
	wire logic [7:0] SFR_RDATA;
	wire logic cnt0, cnt1, irq0_n, irq1_n;
	wire logic [4:0] outs;
	int n_errors, comparisons;
	dtc_pins u_dtc_pins (.clk(CLOCK), .cnt0(cnt0), .cnt1(cnt1),
		.irq0_n(irq0_n), .irq1_n(irq1_n));
	dtc_top u_dtc_top (.CLOCK(CLOCK), .SYS_RST(SYS_RST),
		.SFR_ADDR(SFR_ADDR), .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA),
		.SFR_BIT_WR(SFR_BIT_WR), .SFR_BIT_SEL(SFR_BIT_SEL),
		.SFR_BIT_VAL(SFR_BIT_VAL), .SFR_RDATA(SFR_RDATA),
		.ZERO_COUNT_PIN(cnt0), .ONE_COUNT_PIN(cnt1),
		.EXT_IRQ_ZERO_PIN_N(irq0_n), .EXT_IRQ_ONE_PIN_N(irq1_n),
		.ACK_ZERO_TIMER(ack[0]), .ACK_ONE_TIMER(ack[1]),
		.ACK_EXT_ZERO(ack[2]), .ACK_EXT_ONE(ack[3]),
		.ZERO_TIMER_IRQ(outs[0]), .ONE_TIMER_IRQ(outs[1]),
		.EXT_ZERO_IRQ(outs[2]), .EXT_ONE_IRQ(outs[3]),
		.ONE_OVERFLOW_PULSE(outs[4]));
	task automatic chk(input logic [7:0] got, exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, dat);
		@(posedge CLOCK);
		SFR_ADDR <= a;
		SFR_WDATA <= dat;
		SFR_WR <= 1'b1;
		@(posedge CLOCK);
		SFR_WR <= 1'b0;
	endtask : wr
	task automatic bwr(input int b, input logic v);
		@(posedge CLOCK);
		SFR_BIT_SEL <= 3'(b);
		SFR_BIT_VAL <= v;
		SFR_BIT_WR <= 1'b1;
		@(posedge CLOCK);
		SFR_BIT_WR <= 1'b0;
	endtask : bwr
	// read data is registered: one edge after the address lands
	task automatic rd(input logic [7:0] a, exp, m = 8'hff);
		@(posedge CLOCK);
		SFR_ADDR <= a;
		repeat (2) @(posedge CLOCK);
		#1 chk(SFR_RDATA & m, exp);
	endtask : rd
	task automatic ak(input int i);
		@(posedge CLOCK);
		ack[i] <= 1'b1;
		@(posedge CLOCK);
		ack <= 4'h0;
	endtask : ak
	// bounded watch of one output; expecting a high ends early
	task automatic wt(input int i, n, input logic e);
		logic seen;
		seen = 1'b0;
		repeat (n) begin
			@(posedge CLOCK);
			#1 if (outs[i] === 1'b1) begin
				seen = 1'b1;
				if (e) break;
			end
		end
		chk(8'(seen), 8'(e));
	endtask : wt
	task automatic t_regs;
		for (int a = 8'h88; a <= 8'h8d; a++) rd(8'(a), RESET_COUNT);
		wr(8'h90, 8'h55);
		rd(8'h90, READ_UNMAPPED);
		bwr(BIT_EXT_IRQ_ONE_TYPE, 1'b1);
		rd(ADDR_TIMER_RUN_AND_FLAG_CONTROL, 8'h04);
		wr(ADDR_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
		$display("regs done");
	endtask : t_regs
	task automatic t_modes;
		// mode, low, high, expected both bytes, low-byte mask
		logic [7:0] tab [4][5] = '{'{8'h00, 8'h1f, 8'hff, 8'h00, 8'h1f},
			'{8'h01, 8'hfe, 8'hff, 8'h00, 8'hff},
			'{8'h02, 8'hff, 8'h5a, 8'h5a, 8'hff},
			'{8'h03, 8'hff, 8'h00, 8'h00, 8'hff}};
		foreach (tab[r]) begin
			wr(ADDR_TIMER_MODE_CONTROL, tab[r][0]);
			wr(ADDR_ZERO_LOW_BYTE, tab[r][1]);
			wr(ADDR_ZERO_HIGH_BYTE, tab[r][2]);
			bwr(BIT_ZERO_RUN_BIT, 1'b1);
			wt(0, 14, 1'b1);
			bwr(BIT_ZERO_RUN_BIT, 1'b0);
			rd(ADDR_ZERO_LOW_BYTE, tab[r][3], tab[r][4]);
			rd(ADDR_ZERO_HIGH_BYTE, tab[r][3]);
			ak(0);
			wt(0, 3, 1'b0);
		end
		$display("modes done");
	endtask : t_modes
	task automatic t_split;
		// timer 1 held in its mode 3 while its bytes load
		wr(ADDR_TIMER_MODE_CONTROL, 8'h33);
		wr(ADDR_ZERO_HIGH_BYTE, 8'hff);
		wr(ADDR_ONE_LOW_BYTE, 8'h1f);
		wr(ADDR_ONE_HIGH_BYTE, 8'hff);
		wr(ADDR_TIMER_MODE_CONTROL, 8'h03);
		wt(4, 8, 1'b1);
		chk(8'(outs[1]), 8'h00);
		bwr(BIT_ONE_RUN_BIT, 1'b1);
		wt(1, 8, 1'b1);
		chk(8'(outs[0]), 8'h00);
		bwr(BIT_ONE_RUN_BIT, 1'b0);
		ak(1);
		$display("split done");
	endtask : t_split
	task automatic t_one;
		wr(ADDR_TIMER_MODE_CONTROL, 8'h20);
		wr(ADDR_ONE_LOW_BYTE, 8'hff);
		wr(ADDR_ONE_HIGH_BYTE, 8'hff);
		bwr(BIT_ONE_RUN_BIT, 1'b1);
		wt(1, 8, 1'b1);
		wt(4, 8, 1'b1);
		wr(ADDR_TIMER_MODE_CONTROL, 8'h30);
		ak(1);
		wt(4, 20, 1'b0);
		wt(1, 20, 1'b0);
		bwr(BIT_ONE_RUN_BIT, 1'b0);
		$display("timer one done");
	endtask : t_one
	task automatic t_gate;
		u_dtc_pins.irq(0, 1'b0);
		u_dtc_pins.irq(1, 1'b0);
		wr(ADDR_ZERO_LOW_BYTE, 8'hff);
		wr(ADDR_ZERO_HIGH_BYTE, 8'hff);
		wr(ADDR_ONE_LOW_BYTE, 8'hff);
		wr(ADDR_ONE_HIGH_BYTE, 8'hff);
		wr(ADDR_TIMER_MODE_CONTROL, 8'h99);
		bwr(BIT_ZERO_RUN_BIT, 1'b1);
		bwr(BIT_ONE_RUN_BIT, 1'b1);
		wt(0, 20, 1'b0);
		u_dtc_pins.irq(0, 1'b1);
		wt(0, 14, 1'b1);
		chk(8'(outs[1]), 8'h00);
		u_dtc_pins.irq(1, 1'b1);
		wt(1, 14, 1'b1);
		bwr(BIT_ZERO_RUN_BIT, 1'b0);
		bwr(BIT_ONE_RUN_BIT, 1'b0);
		ak(0);
		ak(1);
		$display("gate done");
	endtask : t_gate
	task automatic t_cnt;
		wr(ADDR_ZERO_LOW_BYTE, 8'hff);
		wr(ADDR_ZERO_HIGH_BYTE, 8'hff);
		wr(ADDR_ONE_LOW_BYTE, 8'hff);
		wr(ADDR_ONE_HIGH_BYTE, 8'hff);
		wr(ADDR_TIMER_MODE_CONTROL, 8'h55);
		bwr(BIT_ZERO_RUN_BIT, 1'b1);
		bwr(BIT_ONE_RUN_BIT, 1'b1);
		wt(0, 20, 1'b0);
		wt(1, 20, 1'b0);
		u_dtc_pins.fall(12);
		wt(0, 20, 1'b1);
		wt(1, 20, 1'b1);
		bwr(BIT_ZERO_RUN_BIT, 1'b0);
		bwr(BIT_ONE_RUN_BIT, 1'b0);
		ak(0);
		ak(1);
		$display("counter done");
	endtask : t_cnt
	task automatic t_ext;
		wr(ADDR_TIMER_RUN_AND_FLAG_CONTROL, 8'h01);
		u_dtc_pins.irq(0, 1'b0);
		wt(2, 10, 1'b1);
		ak(2);
		wt(2, 12, 1'b0);
		u_dtc_pins.irq(0, 1'b1);
		u_dtc_pins.irq(1, 1'b0);
		wt(3, 12, 1'b1);
		ak(3);
		repeat (10) @(posedge CLOCK);
		#1 chk(8'(outs[3]), 8'h01);
		u_dtc_pins.irq(1, 1'b1);
		repeat (8) @(posedge CLOCK);
		wr(ADDR_TIMER_RUN_AND_FLAG_CONTROL, 8'h00);
		rd(ADDR_TIMER_RUN_AND_FLAG_CONTROL, RESET_RUN_AND_FLAG);
		$display("ext done");
	endtask : t_ext
	task automatic conclude;
		$display("comparisons %0d n_errors %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	initial begin
		CLOCK = 1'b0;
		forever #10 CLOCK = ~CLOCK;
	end
	initial begin
		repeat (6000) @(posedge CLOCK);
		n_errors++;
		conclude();
	end
	initial begin
		{SFR_ADDR, SFR_WDATA, SFR_BIT_SEL, SFR_WR, SFR_BIT_WR} = '0;
		{SFR_BIT_VAL, ack} = '0;
		SYS_RST = 1'b1;
		repeat (20) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		t_regs();
		t_modes();
		t_split();
		t_one();
		t_gate();
		t_cnt();
		t_ext();
		conclude();
	end
endmodule : tb_dtc_top
`default_nettype wire
